// ### src/ldc_config_bank.sv
// per-unit configuration register bank behind the index and data ports
//
// Summary of operation
// - eight banks, unit selector picks one
// - index port selects, data port accesses
// - access only in configuration state
// - activate bit 0 sets unit active
// - 0x31 to 0x5F ignore writes, read zero
// - 0x60 high, 0x61 low primary base
// - second base at 0x62 and 0x63
// - unused base registers ignore, read zero
// - primary interrupt select in every bank
// - second interrupt select only keyboard bank
// - interrupts reset to edge, active high
// - unimplemented locations ignore writes, read zero
// - dma select floppy, parallel; 0x75 zero
// - dma select resets to unit default
// - 0xE0 to 0xFF reserved
// - unit on follows linked activate/power bits; a same-cycle data write to the bank drops a power write
// - base outside range makes accesses invalid
// - unit 0 interrupt select resets 0x06
// - dma reset 0x02 floppy, 0x04 parallel
`timescale 1ns/1ps
module ldc_config_bank (
  input  wire logic                 ref_clk,
  input  wire logic                 rstn,
  input  wire logic                 softRst,
  input  wire logic                 cfgMode,
  input  wire logic                 idxWr,
  input  wire logic                 dataWr,
  input  wire logic                 dataRd,
  input  wire logic [7:0]           hostData,
  input  wire logic [2:0]           unitSel,
  input  wire logic                 pwrCtrlWr,
  input  wire logic [2:0]           pwrCtrlUnit,
  input  wire logic                 pwrCtrlVal,
  output logic [7:0]                rdData,
  output logic                      rdValid,
  output logic [ldc_pkg::NUM_UNITS-1:0]       unitOn,
  output logic [ldc_pkg::NUM_UNITS-1:0]       ioDecodeOk,
  output logic [ldc_pkg::NUM_UNITS-1:0][15:0] ioBasePri,
  output logic [ldc_pkg::NUM_UNITS-1:0][15:0] ioBaseSec,
  output logic [ldc_pkg::NUM_UNITS-1:0][7:0]  irqSelPri,
  output logic [ldc_pkg::NUM_UNITS-1:0][7:0]  irqSelSec,
  output logic [ldc_pkg::NUM_UNITS-1:0][7:0]  dmaSel,
  output logic [ldc_pkg::NUM_UNITS-1:0]       irqEdgeMode,
  output logic [ldc_pkg::NUM_UNITS-1:0]       irqActHigh
);
  import ldc_pkg::*;

  // base address check against the unit's window and alignment
  function automatic logic baseInRange(input logic [2:0] unit, input logic [15:0] base);
    logic inWin8;
    logic inWin4;
    inWin8 = (base >= BASE_LOW_LIMIT) && (base <= BASE_HIGH_8B) && (base[2:0] == 3'h0);
    inWin4 = (base >= BASE_LOW_LIMIT) && (base <= BASE_HIGH_4B) && (base[1:0] == 2'h0);
    case (unit)
      FLOPPY_UNIT, SERIAL1_UNIT, SERIAL2_UNIT: return inWin8;
      PARALLEL_UNIT:                           return inWin4;
      // fixed decode, not relocatable
      KEYBOARD_UNIT:                           return 1'b1;
      default:                                 return 1'b0;
    endcase
  endfunction : baseInRange

  //////////////////////////////////////////////////////////////////////////////
  logic [7:0] idx_ff;
  logic [7:0] nxt_idx;
  logic [7:0] rdData_ff;
  logic [7:0] nxt_rdData;
  logic       rdValid_ff;
  logic       nxt_rdValid;
  logic [NUM_UNITS-1:0] decOk_ff;
  logic [NUM_UNITS-1:0] nxt_decOk;
  logic [NUM_UNITS-1:0] irqEdge_ff;
  logic [NUM_UNITS-1:0] irqHigh_ff;

  logic                       cfgWr;
  logic                       cfgRd;
  logic [NUM_UNITS-1:0]       bankWr;
  logic [NUM_UNITS-1:0]       bankPwr;
  logic [NUM_UNITS-1:0][7:0]  bankRd;
  logic [NUM_UNITS-1:0]       act;
  logic [NUM_UNITS-1:0][15:0] basePri;
  logic [NUM_UNITS-1:0][15:0] baseSec;
  logic [NUM_UNITS-1:0][7:0]  irqPri;
  logic [NUM_UNITS-1:0][7:0]  irqSec;
  logic [NUM_UNITS-1:0][7:0]  dma;

  //////////////////////////////////////////////////////////////////////////////
  // ports dead outside configuration state
  assign cfgWr = cfgMode && dataWr;
  assign cfgRd = cfgMode && dataRd;

  always_comb begin
    nxt_idx = idx_ff;
    if (cfgMode && idxWr) begin
      nxt_idx = hostData;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // one bank per unit, steered by selector
  genvar u;
  generate
    for (u = 0; u < NUM_UNITS; u++) begin : g_unit
      assign bankWr[u]  = cfgWr && (unitSel == 3'(u));
      assign bankPwr[u] = pwrCtrlWr && (pwrCtrlUnit == 3'(u));

      ldc_unit_bank #(
        .UNIT (3'(u))
      ) u_bank (
        .ref_clk    (ref_clk),
        .rstn       (rstn),
        .softRst    (softRst),
        .wrEn       (bankWr[u]),
        .wrIdx      (idx_ff),
        .wrData     (hostData),
        .pwrWr      (bankPwr[u]),
        .pwrVal     (pwrCtrlVal),
        .rdIdx      (idx_ff),
        .rdByte     (bankRd[u]),
        .act_ff     (act[u]),
        .basePri_ff (basePri[u]),
        .baseSec_ff (baseSec[u]),
        .irqPri_ff  (irqPri[u]),
        .irqSec_ff  (irqSec[u]),
        .dma_ff     (dma[u])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_rdData  = rdData_ff;
    nxt_rdValid = 1'b0;
    // read the indexed register of selected bank
    if (cfgRd) begin
      nxt_rdData  = bankRd[unitSel];
      nxt_rdValid = 1'b1;
    end
    // decode only when on and in range
    for (int i = 0; i < NUM_UNITS; i++) begin
      nxt_decOk[i] = act[i] && baseInRange(3'(i), basePri[i]);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      idx_ff     <= 8'h00;
      rdData_ff  <= 8'h00;
      rdValid_ff <= 1'b0;
      decOk_ff   <= '0;
      irqEdge_ff <= {NUM_UNITS{IRQ_EDGE_RST}};
      irqHigh_ff <= {NUM_UNITS{IRQ_HIGH_RST}};
    end else begin
      idx_ff     <= nxt_idx;
      rdData_ff  <= nxt_rdData;
      rdValid_ff <= nxt_rdValid;
      decOk_ff   <= nxt_decOk;
      irqEdge_ff <= irqEdge_ff;
      irqHigh_ff <= irqHigh_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  assign rdData      = rdData_ff;
  assign rdValid     = rdValid_ff;
  assign unitOn      = act;
  assign ioDecodeOk  = decOk_ff;
  assign ioBasePri   = basePri;
  assign ioBaseSec   = baseSec;
  assign irqSelPri   = irqPri;
  assign irqSelSec   = irqSec;
  assign dmaSel      = dma;
  assign irqEdgeMode = irqEdge_ff;
  assign irqActHigh  = irqHigh_ff;

endmodule : ldc_config_bank

// ### inc/ldc_pkg.sv
// constants and helpers shared by the per-unit configuration register bank
package ldc_pkg;

  localparam int NUM_UNITS = 8;

  // per-unit register indices
  localparam logic [7:0] ACT_IDX         = 8'h30;
  localparam logic [7:0] BASE_PRI_HI_IDX = 8'h60;
  localparam logic [7:0] BASE_PRI_LO_IDX = 8'h61;
  localparam logic [7:0] BASE_SEC_HI_IDX = 8'h62;
  localparam logic [7:0] BASE_SEC_LO_IDX = 8'h63;
  localparam logic [7:0] IRQ_PRI_IDX     = 8'h70;
  localparam logic [7:0] IRQ_SEC_IDX     = 8'h72;
  localparam logic [7:0] DMA_SEL_IDX     = 8'h74;

  // field positions
  localparam int ACT_BIT = 0;

  // logical unit numbers
  localparam logic [2:0] FLOPPY_UNIT   = 3'h0;
  localparam logic [2:0] PARALLEL_UNIT = 3'h3;
  localparam logic [2:0] SERIAL1_UNIT  = 3'h4;
  localparam logic [2:0] SERIAL2_UNIT  = 3'h5;
  localparam logic [2:0] KEYBOARD_UNIT = 3'h7;

  // values after reset
  localparam logic [7:0]  ACT_RST        = 8'h00;
  localparam logic [15:0] BASE_RST       = 16'h0000;
  localparam logic [7:0]  IRQ_PRI_RST_U0 = 8'h06;
  localparam logic [7:0]  IRQ_PRI_RST    = 8'h00;
  localparam logic [7:0]  IRQ_SEC_RST    = 8'h00;
  localparam logic [7:0]  DMA_RST_FLOPPY = 8'h02;
  localparam logic [7:0]  DMA_RST_PAR    = 8'h04;
  localparam logic [7:0]  DMA_RST_NONE   = 8'h00;
  localparam logic        IRQ_EDGE_RST   = 1'b1;
  localparam logic        IRQ_HIGH_RST   = 1'b1;

  // permitted base ranges
  localparam logic [15:0] BASE_LOW_LIMIT  = 16'h0100;
  localparam logic [15:0] BASE_HIGH_8B    = 16'h0FF8;
  localparam logic [15:0] BASE_HIGH_4B    = 16'h0FFC;

  // units that use the second base pair (none among units 0 to 7)
  localparam logic [7:0] SEC_BASE_MASK = 8'h00;

  function automatic logic unitUsesBase(input logic [2:0] unit);
    return (unit == FLOPPY_UNIT) || (unit == PARALLEL_UNIT) ||
           (unit == SERIAL1_UNIT) || (unit == SERIAL2_UNIT);
  endfunction : unitUsesBase

  function automatic logic unitUsesDma(input logic [2:0] unit);
    return (unit == FLOPPY_UNIT) || (unit == PARALLEL_UNIT);
  endfunction : unitUsesDma

  function automatic logic [7:0] irqPriReset(input logic [2:0] unit);
    return (unit == FLOPPY_UNIT) ? IRQ_PRI_RST_U0 : IRQ_PRI_RST;
  endfunction : irqPriReset

  function automatic logic [7:0] dmaReset(input logic [2:0] unit);
    if (unit == FLOPPY_UNIT) begin
      return DMA_RST_FLOPPY;
    end
    if (unit == PARALLEL_UNIT) begin
      return DMA_RST_PAR;
    end
    return DMA_RST_NONE;
  endfunction : dmaReset

endpackage : ldc_pkg

// ### src/ldc_unit_bank.sv
// one logical unit's configuration registers
`timescale 1ns/1ps
module ldc_unit_bank #(
  parameter logic [2:0] UNIT = 3'h0
) (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        softRst,
  input  wire logic        wrEn,
  input  wire logic [7:0]  wrIdx,
  input  wire logic [7:0]  wrData,
  input  wire logic        pwrWr,
  input  wire logic        pwrVal,
  input  wire logic [7:0]  rdIdx,
  output logic [7:0]       rdByte,
  output logic             act_ff,
  output logic [15:0]      basePri_ff,
  output logic [15:0]      baseSec_ff,
  output logic [7:0]       irqPri_ff,
  output logic [7:0]       irqSec_ff,
  output logic [7:0]       dma_ff
);
  import ldc_pkg::*;

  localparam logic HAS_BASE = unitUsesBase(UNIT);
  localparam logic HAS_SEC  = SEC_BASE_MASK[UNIT];
  localparam logic HAS_IRQ2 = (UNIT == KEYBOARD_UNIT);
  localparam logic HAS_DMA  = unitUsesDma(UNIT);

  logic        nxt_act;
  logic [15:0] nxt_basePri;
  logic [15:0] nxt_baseSec;
  logic [7:0]  nxt_irqPri;
  logic [7:0]  nxt_irqSec;
  logic [7:0]  nxt_dma;

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    nxt_act     = act_ff;
    nxt_basePri = basePri_ff;
    nxt_baseSec = baseSec_ff;
    nxt_irqPri  = irqPri_ff;
    nxt_irqSec  = irqSec_ff;
    nxt_dma     = dma_ff;
    if (softRst) begin
      nxt_act     = ACT_RST[ACT_BIT];
      nxt_basePri = BASE_RST;
      nxt_baseSec = BASE_RST;
      nxt_irqPri  = irqPriReset(UNIT);
      nxt_irqSec  = IRQ_SEC_RST;
      nxt_dma     = dmaReset(UNIT);
    end else if (wrEn) begin
      case (wrIdx)
        ACT_IDX: begin
          nxt_act = wrData[ACT_BIT];
        end
        BASE_PRI_HI_IDX: begin
          if (HAS_BASE) nxt_basePri[15:8] = wrData;
        end
        BASE_PRI_LO_IDX: begin
          if (HAS_BASE) nxt_basePri[7:0] = wrData;
        end
        BASE_SEC_HI_IDX: begin
          if (HAS_SEC) nxt_baseSec[15:8] = wrData;
        end
        BASE_SEC_LO_IDX: begin
          if (HAS_SEC) nxt_baseSec[7:0] = wrData;
        end
        IRQ_PRI_IDX: begin
          nxt_irqPri = wrData;
        end
        IRQ_SEC_IDX: begin
          if (HAS_IRQ2) nxt_irqSec = wrData;
        end
        DMA_SEL_IDX: begin
          if (HAS_DMA) nxt_dma = wrData;
        end
        default: begin
        end
      endcase
    end else if (pwrWr) begin
      nxt_act = pwrVal;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      act_ff     <= ACT_RST[ACT_BIT];
      basePri_ff <= BASE_RST;
      baseSec_ff <= BASE_RST;
      irqPri_ff  <= irqPriReset(UNIT);
      irqSec_ff  <= IRQ_SEC_RST;
      dma_ff     <= dmaReset(UNIT);
    end else begin
      act_ff     <= nxt_act;
      basePri_ff <= nxt_basePri;
      baseSec_ff <= nxt_baseSec;
      irqPri_ff  <= nxt_irqPri;
      irqSec_ff  <= nxt_irqSec;
      dma_ff     <= nxt_dma;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // unlisted locations read zero
  always_comb begin
    rdByte = 8'h00;
    case (rdIdx)
      ACT_IDX:         rdByte = {7'h00, act_ff};
      BASE_PRI_HI_IDX: rdByte = basePri_ff[15:8];
      BASE_PRI_LO_IDX: rdByte = basePri_ff[7:0];
      BASE_SEC_HI_IDX: rdByte = baseSec_ff[15:8];
      BASE_SEC_LO_IDX: rdByte = baseSec_ff[7:0];
      IRQ_PRI_IDX:     rdByte = irqPri_ff;
      IRQ_SEC_IDX:     rdByte = irqSec_ff;
      DMA_SEL_IDX:     rdByte = dma_ff;
      default:         rdByte = 8'h00;
    endcase
  end

endmodule : ldc_unit_bank

// ### dv/ldc_config_bank_properties.sv
// concurrent checks on the configuration register bank ports
`timescale 1ns/1ps
module ldc_config_bank_properties (
  input wire logic            ref_clk,
  input wire logic            rstn,
  input wire logic            softRst,
  input wire logic            cfgMode,
  input wire logic            idxWr,
  input wire logic            dataWr,
  input wire logic            dataRd,
  input wire logic [7:0]      hostData,
  input wire logic [2:0]      unitSel,
  input wire logic            pwrCtrlWr,
  input wire logic [7:0]      rdData,
  input wire logic            rdValid,
  input wire logic [7:0]      unitOn,
  input wire logic [7:0][15:0] ioBaseSec,
  input wire logic [7:0][7:0] irqSelSec,
  input wire logic [7:0][7:0] dmaSel,
  input wire logic [7:0]      irqEdgeMode,
  input wire logic [7:0]      irqActHigh
);
  logic [7:0] idxQ_ff;
  logic [7:0] nxt_idxQ;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // shadow of the index so data accesses can be decoded here
  always_comb begin
    nxt_idxQ = (cfgMode && idxWr) ? hostData : idxQ_ff;
  end
  always_ff @(posedge ref_clk) begin
    idxQ_ff <= rstn ? nxt_idxQ : 8'h00;
  end
  ////////////////////////////////////////////////////////////////
  property p_rd_ans;
    cfgMode && dataRd |=> rdValid;
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
  property p_rd_gate;
    !(cfgMode && dataRd) |=> !rdValid;
  endproperty
  a_rd_gate: assert property (p_rd_gate) else $error("read answered outside config");
  property p_cfg_hold;
    !cfgMode && !pwrCtrlWr && !softRst |=> $stable(unitOn);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("unit on changed outside config");
  property p_act_wr;
    cfgMode && dataWr && idxQ_ff == 8'h30 && !softRst |=> unitOn[$past(unitSel)] == $past(hostData[0]);
  endproperty
  a_act_wr: assert property (p_act_wr) else $error("activate write lost");
  property p_resv_rd;
    cfgMode && dataRd && idxQ_ff inside {[8'h31:8'h5F]} |=> rdData == 8'h00;
  endproperty
  a_resv_rd: assert property (p_resv_rd) else $error("reserved read not zero");
  property p_sec_base;
    ioBaseSec == '0;
  endproperty
  a_sec_base: assert property (p_sec_base) else $error("second base not zero");
  property p_sec_irq;
    irqSelSec[6:0] == '0;
  endproperty
  a_sec_irq: assert property (p_sec_irq) else $error("second irq set outside keyboard");
  property p_irq_mode;
    (&irqEdgeMode) && (&irqActHigh);
  endproperty
  a_irq_mode: assert property (p_irq_mode) else $error("irq mode not edge high");
  property p_dma_wr;
    cfgMode && dataWr && !softRst && idxQ_ff == 8'h74 && unitSel == 3'h3 |=> dmaSel[3] == $past(hostData);
  endproperty
  a_dma_wr: assert property (p_dma_wr) else $error("dma select write lost");
  property p_soft;
    softRst |=> unitOn == 8'h00 && dmaSel[0] == 8'h02 && dmaSel[3] == 8'h04;
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset defaults wrong");
  c_read: cover property (cfgMode && dataRd);
  c_soft: cover property (softRst);
  c_pwr: cover property (pwrCtrlWr);
endmodule : ldc_config_bank_properties

bind ldc_config_bank ldc_config_bank_properties u_props (.ref_clk(ref_clk), .rstn(rstn), .softRst(softRst),
  .cfgMode(cfgMode), .idxWr(idxWr), .dataWr(dataWr), .dataRd(dataRd), .hostData(hostData), .unitSel(unitSel),
  .pwrCtrlWr(pwrCtrlWr), .rdData(rdData), .rdValid(rdValid), .unitOn(unitOn), .ioBaseSec(ioBaseSec),
  .irqSelSec(irqSelSec), .dmaSel(dmaSel), .irqEdgeMode(irqEdgeMode), .irqActHigh(irqActHigh));

// ### dv/ldc_host_model.sv
// host software model driving the index and data ports
`timescale 1ns/1ps
module ldc_host_model (
  input  wire logic       ref_clk,
  input  wire logic [7:0] rdData,
  input  wire logic       rdValid,
  output logic            cfgMode,
  output logic            idxWr,
  output logic            dataWr,
  output logic            dataRd,
  output logic [7:0]      hostData
);
  initial begin
    cfgMode = 1'b1;
    idxWr = 1'b0;
    dataWr = 1'b0;
    dataRd = 1'b0;
    hostData = 8'h00;
  end
  task automatic wr(input logic c, input logic [7:0] i, input logic [7:0] d);
    @(negedge ref_clk);
    cfgMode = c;
    idxWr = 1'b1;
    hostData = i;
    @(negedge ref_clk);
    idxWr = 1'b0;
    dataWr = 1'b1;
    hostData = d;
    @(negedge ref_clk);
    dataWr = 1'b0;
    hostData = ~d;
    cfgMode = 1'b1;
  endtask : wr
  task automatic rd(input logic c, input logic [7:0] i, output logic [7:0] d);
    @(negedge ref_clk);
    cfgMode = c;
    idxWr = 1'b1;
    hostData = i;
    @(negedge ref_clk);
    idxWr = 1'b0;
    hostData = ~i;
    dataRd = 1'b1;
    @(negedge ref_clk);
    dataRd = 1'b0;
    d = rdValid ? rdData : 8'hxx;
    cfgMode = 1'b1;
  endtask : rd
endmodule : ldc_host_model

// ### dv/ldc_config_bank_tb.sv
// self-checking bench for the configuration register bank
`timescale 1ns/1ps
module ldc_config_bank_tb;
  import ldc_pkg::*;
  typedef struct packed {logic [2:0] u; logic [7:0] i; logic [7:0] w; logic [7:0] e;} ldc_row_t;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic softRst = 1'b0;
  logic pwrCtrlWr = 1'b0;
  logic pwrCtrlVal = 1'b0;
  logic [2:0] unitSel = 3'h0;
  logic [2:0] pwrCtrlUnit = 3'h0;
  logic cfgMode, idxWr, dataWr, dataRd, rdValid;
  logic [7:0] hostData, rdData, got, unitOn, ioDecodeOk, irqEdgeMode, irqActHigh;
  logic [7:0][15:0] ioBasePri, ioBaseSec;
  logic [7:0][7:0] irqSelPri, irqSelSec, dmaSel;
  int n_errors = 0;
  int compares = 0;
  ldc_row_t rows [0:17] = '{
    '{3'h0, 8'h60, 8'h03, 8'h03}, '{3'h0, 8'h61, 8'hF8, 8'hF8},
    '{3'h0, 8'h30, 8'hFF, 8'h01}, '{3'h0, 8'h62, 8'h12, 8'h00},
    '{3'h0, 8'h35, 8'hAA, 8'h00}, '{3'h0, 8'h45, 8'hAA, 8'h00},
    '{3'h1, 8'h60, 8'h12, 8'h00}, '{3'h2, 8'h70, 8'h05, 8'h05},
    '{3'h0, 8'h72, 8'h05, 8'h00}, '{3'h7, 8'h72, 8'h0C, 8'h0C},
    '{3'h0, 8'h71, 8'h11, 8'h00}, '{3'h0, 8'h73, 8'h11, 8'h00},
    '{3'h0, 8'h80, 8'h11, 8'h00}, '{3'h0, 8'hC0, 8'h11, 8'h00},
    '{3'h3, 8'h74, 8'h01, 8'h01}, '{3'h1, 8'h74, 8'h01, 8'h00},
    '{3'h0, 8'h75, 8'h01, 8'h00}, '{3'h0, 8'hE0, 8'h01, 8'h00}
  };
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  ldc_host_model host (.ref_clk(ref_clk), .rdData(rdData), .rdValid(rdValid), .cfgMode(cfgMode),
    .idxWr(idxWr), .dataWr(dataWr), .dataRd(dataRd), .hostData(hostData));
  ldc_config_bank DUT (.ref_clk(ref_clk), .rstn(rstn), .softRst(softRst), .cfgMode(cfgMode), .idxWr(idxWr),
    .dataWr(dataWr), .dataRd(dataRd), .hostData(hostData), .unitSel(unitSel), .pwrCtrlWr(pwrCtrlWr),
    .pwrCtrlUnit(pwrCtrlUnit), .pwrCtrlVal(pwrCtrlVal), .rdData(rdData), .rdValid(rdValid),
    .unitOn(unitOn), .ioDecodeOk(ioDecodeOk), .ioBasePri(ioBasePri), .ioBaseSec(ioBaseSec),
    .irqSelPri(irqSelPri), .irqSelSec(irqSelSec), .dmaSel(dmaSel), .irqEdgeMode(irqEdgeMode),
    .irqActHigh(irqActHigh));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] act);
    compares++;
    if (act !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, act);
    end
  endtask : chk
  task automatic close_out();
    if (n_errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out
  // bounded run, about twenty times the expected length
  initial begin
    #(50 * 3000);
    n_errors++;
    close_out();
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(negedge ref_clk);
    rstn = 1'b1;
    host.rd(1'b1, IRQ_PRI_IDX, got);
    chk("irq0 default", 16'h0006, got);
    host.rd(1'b1, DMA_SEL_IDX, got);
    chk("dma0 default", 16'h0002, got);
    chk("dma3 default", 16'h0004, dmaSel[3]);
    chk("edge high", 16'hFFFF, {irqEdgeMode, irqActHigh});
    foreach (rows[k]) begin
      unitSel = rows[k].u;
      host.wr(1'b1, rows[k].i, rows[k].w);
      host.rd(1'b1, rows[k].i, got);
      chk("row read", rows[k].e, got);
    end
    unitSel = 3'h0;
    chk("base0", 16'h03F8, ioBasePri[0]);
    chk("decode ok", 16'h0001, ioDecodeOk[0]);
    // misaligned base must drop decode
    host.wr(1'b1, BASE_PRI_LO_IDX, 8'hF9);
    @(negedge ref_clk);
    chk("decode bad", 16'h0000, ioDecodeOk[0]);
    unitSel = 3'h2;
    host.wr(1'b0, IRQ_PRI_IDX, 8'h0F);
    host.rd(1'b1, IRQ_PRI_IDX, got);
    chk("cfg off write", 16'h0005, got);
    // read strobe outside configuration state must stay unanswered
    host.rd(1'b0, IRQ_PRI_IDX, got);
    chk("cfg off read", 16'h0000, rdValid);
    pwrCtrlUnit = 3'h5;
    pwrCtrlVal = 1'b1;
    pwrCtrlWr = 1'b1;
    @(negedge ref_clk);
    pwrCtrlWr = 1'b0;
    unitSel = 3'h5;
    host.rd(1'b1, ACT_IDX, got);
    chk("power links act", 16'h0001, got);
    host.wr(1'b1, ACT_IDX, 8'h00);
    chk("unit on", 16'h0001, unitOn);
    softRst = 1'b1;
    @(negedge ref_clk);
    softRst = 1'b0;
    chk("soft on", 16'h0000, unitOn);
    chk("soft base", 16'h0000, ioBasePri[0]);
    chk("soft irq", 16'h0600, {irqSelPri[0], irqSelPri[2]});
    chk("soft irq sec", 16'h0000, irqSelSec[7]);
    // mid-run hard reset over a dirtied select and a nonzero read value
    unitSel = 3'h0;
    host.wr(1'b1, IRQ_PRI_IDX, 8'h0F);
    rstn = 1'b0;
    @(negedge ref_clk);
    rstn = 1'b1;
    chk("hard irq", 16'h0006, irqSelPri[0]);
    chk("hard rd data", 16'h0000, rdData);
    chk("hard valid", 16'h0000, rdValid);
    close_out();
  end
endmodule : ldc_config_bank_tb
